// *** calu_pkg.sv ***
// Function
// - pointer add: signed 6-bit literal, flags untouched
// - pointer sum wraps modulo 65536
// - AND immediate into accumulator, zero flag only
// - add immediate into accumulator, carry nibble zero
// - AND file with accumulator, zero flag only
// - destination bit 0 accumulator, 1 file
// - add file and accumulator, carry nibble zero
// - arithmetic shift right, old bit0 to carry
// - add file, accumulator and carry, all flags
// - clear bit b of file, no flags
// - indirect port, pointer MSb set: extra cycle
`default_nettype none
package calu_pkg;

	// register byte offsets on the bus
	localparam logic [7:0] CALU_OFS_CMD    = 8'h00;
	localparam logic [7:0] CALU_OFS_ACCUM  = 8'h04;
	localparam logic [7:0] CALU_OFS_STATUS = 8'h08;
	localparam logic [7:0] CALU_OFS_PTR0   = 8'h0C;
	localparam logic [7:0] CALU_OFS_PTR1   = 8'h10;
	localparam logic [7:0] CALU_OFS_FADDR  = 8'h14;
	localparam logic [7:0] CALU_OFS_FDATA  = 8'h18;
	localparam logic [7:0] CALU_OFS_STATE  = 8'h1C;

	// command word fields
	localparam int CALU_CMD_OP_LSB   = 0;
	localparam int CALU_CMD_DEST_BIT = 3;
	localparam int CALU_CMD_BIT_LSB  = 4;
	localparam int CALU_CMD_PTR_BIT  = 7;
	localparam int CALU_CMD_FILE_LSB = 8;
	localparam int CALU_CMD_LIT_LSB  = 16;

	// status register bit positions
	localparam int CALU_ST_CARRY  = 0;
	localparam int CALU_ST_NIBBLE = 1;
	localparam int CALU_ST_ZERO   = 2;

	// file addresses that act as indirect access ports
	localparam logic [6:0] CALU_IND_PORT0 = 7'h00;
	localparam logic [6:0] CALU_IND_PORT1 = 7'h01;

	// reset values
	localparam logic [7:0]  CALU_RST_ACCUM = 8'h00;
	localparam logic [2:0]  CALU_RST_FLAGS = 3'h0;
	localparam logic [15:0] CALU_RST_PTR   = 16'h0000;

	// one instruction cycle and its length in clocks
	localparam int CALU_CLOCK_MHZ     = 40;
	localparam int CALU_INSTR_CYC_NS  = 100;
	localparam int CALU_INSTR_CLKS    = (CALU_INSTR_CYC_NS * CALU_CLOCK_MHZ + 999) / 1000;

	typedef enum logic [2:0] {
		CALU_OP_PTR_ADD   = 3'h0,
		CALU_OP_AND_IMM   = 3'h1,
		CALU_OP_SUM_IMM   = 3'h2,
		CALU_OP_AND_FILE  = 3'h3,
		CALU_OP_SUM_FILE  = 3'h4,
		CALU_OP_ASR       = 3'h5,
		CALU_OP_SUM_FILEC = 3'h6,
		CALU_OP_BIT_CLR   = 3'h7
	} calu_op_e;

	typedef enum logic [1:0] {
		CALU_ST_IDLE = 2'b01,
		CALU_ST_RUN  = 2'b10
	} calu_state_e;

endpackage
`default_nettype wire

// *** calu_core.sv ***
`timescale 1ns/1ps
`default_nettype none
module calu_core (
	input  wire logic        clock,
	input  wire logic        reset,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	output logic             busy
);

	////////////////////////////////////////////////////////////////////////
	// state

	calu_pkg::calu_state_e state_q;
	logic [23:0]  cmd_q;
	logic [7:0]   accum_q;
	logic [2:0]   flags_q;
	logic [15:0]  ptr_q [2];
	logic [6:0]   faddr_q;
	logic [7:0]   file_q [128];
	logic [3:0]   cnt_q;
	logic         ack_q;
	logic [31:0]  prdata_q;

	////////////////////////////////////////////////////////////////////////
	// bus decode

	logic         wr_take;
	logic         rd_take;
	logic         mapped;
	logic [31:0]  rd_mux;
	logic [31:0]  bmask;
	logic         commit;

	// byte enables widen to a bit mask
	assign bmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

	// read mux; an unmapped address reads zero and flags an error
	always_comb begin
		mapped = 1'b1;
		case (paddr)
			calu_pkg::CALU_OFS_CMD:    rd_mux = {8'h00, cmd_q};
			calu_pkg::CALU_OFS_ACCUM:  rd_mux = {24'h000000, accum_q};
			calu_pkg::CALU_OFS_STATUS: rd_mux = {29'h00000000, flags_q};
			calu_pkg::CALU_OFS_PTR0:   rd_mux = {16'h0000, ptr_q[0]};
			calu_pkg::CALU_OFS_PTR1:   rd_mux = {16'h0000, ptr_q[1]};
			calu_pkg::CALU_OFS_FADDR:  rd_mux = {25'h0000000, faddr_q};
			calu_pkg::CALU_OFS_FDATA:  rd_mux = {24'h000000, file_q[faddr_q]};
			calu_pkg::CALU_OFS_STATE:  rd_mux = {31'h00000000, busy};
			default: begin
				rd_mux = 32'h00000000;
				mapped = 1'b0;
			end
		endcase
	end

	// one wait state, and none accepted while an instruction runs
	always_ff @(posedge clock) begin
		if (reset) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= psel & penable & ~ack_q & ~busy;
		end
	end

	// read data captured during the wait state so it stands at the completing edge
	always_ff @(posedge clock) begin
		if (reset) begin
			prdata_q <= 32'h00000000;
		end else if (psel & penable & ~ack_q & ~busy) begin
			prdata_q <= pwrite ? 32'h00000000 : rd_mux;
		end
	end

	// handshake straight from the ack flop; a refused address still completes
	assign pready  = ack_q;
	assign prdata  = prdata_q;
	assign pslverr = ack_q & ~mapped;
	assign wr_take = psel & penable & ack_q & pwrite & mapped;
	assign rd_take = psel & penable & ack_q & ~pwrite;

	// byte-lane merge, so a partial write keeps the lanes it does not enable
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [31:0] m);
		merge = (old & ~m) | (nw & m);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// operand fetch

	calu_pkg::calu_op_e op;
	logic         dest;
	logic [2:0]   bsel;
	logic         psel_idx;
	logic [6:0]   fsel;
	logic [7:0]   lit;
	logic [6:0]   eaddr;
	logic         ind_slow;
	logic [7:0]   fval;

	// command word fields; every op code is defined, so the cast is always legal
	assign op       = calu_pkg::calu_op_e'(cmd_q[calu_pkg::CALU_CMD_OP_LSB +: 3]);
	assign dest     = cmd_q[calu_pkg::CALU_CMD_DEST_BIT];
	assign bsel     = cmd_q[calu_pkg::CALU_CMD_BIT_LSB +: 3];
	assign psel_idx = cmd_q[calu_pkg::CALU_CMD_PTR_BIT];
	assign fsel     = cmd_q[calu_pkg::CALU_CMD_FILE_LSB +: 7];
	assign lit      = cmd_q[calu_pkg::CALU_CMD_LIT_LSB +: 8];

	// an indirect port reaches the file through the low bits of its pointer
	always_comb begin
		ind_slow = 1'b0;
		eaddr    = fsel;
		if (op != calu_pkg::CALU_OP_PTR_ADD && op != calu_pkg::CALU_OP_AND_IMM &&
		    op != calu_pkg::CALU_OP_SUM_IMM) begin
			if (fsel == calu_pkg::CALU_IND_PORT0) begin
				eaddr    = ptr_q[0][6:0];
				ind_slow = ptr_q[0][15];
			end else if (fsel == calu_pkg::CALU_IND_PORT1) begin
				eaddr    = ptr_q[1][6:0];
				ind_slow = ptr_q[1][15];
			end
		end
	end

	// one read port of the file serves every file operand
	assign fval = file_q[eaddr];

	////////////////////////////////////////////////////////////////////////
	// arithmetic

	logic [7:0]   addend;
	logic         cin;
	logic [8:0]   sum9;
	logic [4:0]   nib5;
	logic [7:0]   res;
	logic [2:0]   flags_d;
	logic         to_accum;
	logic         to_file;
	logic [15:0]  ptr_sum;

	// literal operations add the immediate, the rest add the file byte
	assign addend = (op == calu_pkg::CALU_OP_SUM_IMM) ? lit : fval;
	assign cin    = (op == calu_pkg::CALU_OP_SUM_FILEC) ? flags_q[calu_pkg::CALU_ST_CARRY] : 1'b0;
	assign sum9   = {1'b0, accum_q} + {1'b0, addend} + {8'h00, cin};
	assign nib5   = {1'b0, accum_q[3:0]} + {1'b0, addend[3:0]} + {4'h0, cin};

	// sign-extended literal added with natural 16-bit wrap
	assign ptr_sum = ptr_q[psel_idx] + {{10{lit[5]}}, lit[5:0]};

	always_comb begin
		flags_d  = flags_q;
		res      = 8'h00;
		to_accum = 1'b0;
		to_file  = 1'b0;
		case (op)
			calu_pkg::CALU_OP_PTR_ADD: begin
				res = 8'h00;
			end
			calu_pkg::CALU_OP_AND_IMM: begin
				res      = accum_q & lit;
				to_accum = 1'b1;
				flags_d[calu_pkg::CALU_ST_ZERO] = (res == 8'h00);
			end
			calu_pkg::CALU_OP_AND_FILE: begin
				res      = accum_q & fval;
				to_accum = ~dest;
				to_file  = dest;
				flags_d[calu_pkg::CALU_ST_ZERO] = (res == 8'h00);
			end
			calu_pkg::CALU_OP_SUM_IMM, calu_pkg::CALU_OP_SUM_FILE, calu_pkg::CALU_OP_SUM_FILEC: begin
				res      = sum9[7:0];
				to_accum = (op == calu_pkg::CALU_OP_SUM_IMM) | ~dest;
				to_file  = (op != calu_pkg::CALU_OP_SUM_IMM) & dest;
				flags_d[calu_pkg::CALU_ST_CARRY]  = sum9[8];
				flags_d[calu_pkg::CALU_ST_NIBBLE] = nib5[4];
				flags_d[calu_pkg::CALU_ST_ZERO]   = (res == 8'h00);
			end
			calu_pkg::CALU_OP_ASR: begin
				res      = {fval[7], fval[7:1]};
				to_accum = ~dest;
				to_file  = dest;
				flags_d[calu_pkg::CALU_ST_CARRY] = fval[0];
				flags_d[calu_pkg::CALU_ST_ZERO]  = (res == 8'h00);
			end
			calu_pkg::CALU_OP_BIT_CLR: begin
				res     = fval & ~(8'h01 << bsel);
				to_file = 1'b1;
			end
			default: begin
				res = 8'h00;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// sequencing: one instruction cycle, two through a slow indirect port

	logic [3:0]   cnt_last;

	assign cnt_last = ind_slow ? 4'(2 * calu_pkg::CALU_INSTR_CLKS - 1)
	                           : 4'(calu_pkg::CALU_INSTR_CLKS - 1);
	assign commit   = (state_q == calu_pkg::CALU_ST_RUN) && (cnt_q == cnt_last);
	assign busy     = (state_q == calu_pkg::CALU_ST_RUN);

	// idle waits for a command write; run counts clocks up to the commit edge
	always_ff @(posedge clock) begin
		if (reset) begin
			state_q <= calu_pkg::CALU_ST_IDLE;
			cnt_q   <= 4'h0;
		end else begin
			case (state_q)
				calu_pkg::CALU_ST_IDLE: begin
					cnt_q <= 4'h0;
					if (wr_take && paddr == calu_pkg::CALU_OFS_CMD && pstrb[0]) begin
						state_q <= calu_pkg::CALU_ST_RUN;
					end
				end
				calu_pkg::CALU_ST_RUN: begin
					cnt_q <= cnt_q + 4'h1;
					if (commit) begin
						state_q <= calu_pkg::CALU_ST_IDLE;
					end
				end
				default: begin
					state_q <= calu_pkg::CALU_ST_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// architectural registers; bus writes cannot meet a commit since the bus stalls while busy

	// command word keeps its value, so software can read back what ran
	always_ff @(posedge clock) begin
		if (reset) begin
			cmd_q <= 24'h000000;
		end else if (wr_take && paddr == calu_pkg::CALU_OFS_CMD) begin
			cmd_q <= 24'(merge({8'h00, cmd_q}, pwdata, bmask));
		end
	end

	// a commit wins over a bus write, though the stall keeps them apart
	always_ff @(posedge clock) begin
		if (reset) begin
			accum_q <= calu_pkg::CALU_RST_ACCUM;
		end else if (commit && to_accum) begin
			accum_q <= res;
		end else if (wr_take && paddr == calu_pkg::CALU_OFS_ACCUM && pstrb[0]) begin
			accum_q <= pwdata[7:0];
		end
	end

	// flags follow the executed op; software may preload them for add with carry
	always_ff @(posedge clock) begin
		if (reset) begin
			flags_q <= calu_pkg::CALU_RST_FLAGS;
		end else if (commit) begin
			flags_q <= flags_d;
		end else if (wr_take && paddr == calu_pkg::CALU_OFS_STATUS && pstrb[0]) begin
			flags_q <= pwdata[2:0];
		end
	end

	// one pointer register per index; pointer add and bus writes both reach it
	for (genvar i = 0; i < 2; i++) begin : g_ptr
		always_ff @(posedge clock) begin
			if (reset) begin
				ptr_q[i] <= calu_pkg::CALU_RST_PTR;
			end else if (commit && op == calu_pkg::CALU_OP_PTR_ADD && psel_idx == 1'(i)) begin
				ptr_q[i] <= ptr_sum;
			end else if (wr_take && paddr == (i == 0 ? calu_pkg::CALU_OFS_PTR0 : calu_pkg::CALU_OFS_PTR1)) begin
				ptr_q[i] <= 16'(merge({16'h0000, ptr_q[i]}, pwdata, bmask));
			end
		end
	end

	// file address for the data window; only seven bits exist
	always_ff @(posedge clock) begin
		if (reset) begin
			faddr_q <= 7'h00;
		end else if (wr_take && paddr == calu_pkg::CALU_OFS_FADDR && pstrb[0]) begin
			faddr_q <= pwdata[6:0];
		end
	end

	// data file has no reset; software loads it before use
	always_ff @(posedge clock) begin
		if (commit && to_file) begin
			file_q[eaddr] <= res;
		end else if (wr_take && paddr == calu_pkg::CALU_OFS_FDATA && pstrb[0]) begin
			file_q[faddr_q] <= pwdata[7:0];
		end
	end

endmodule // calu_core
`default_nettype wire

// *** calu_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module calu_checker (
	input wire logic        clock,
	input wire logic        reset,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic        pready,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	input wire logic        busy
);
	logic [3:0] busy_cnt_q;
	logic       cmd_q;
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);
	// length of the current busy run, so the figure can be checked when it ends
	always_ff @(posedge clock) begin
		if (reset || !busy) busy_cnt_q <= 4'h0;
		else                busy_cnt_q <= busy_cnt_q + 4'h1;
	end
	// remembers a completed command write; busy may only start from one
	always_ff @(posedge clock) begin
		if (reset) cmd_q <= 1'b0;
		else       cmd_q <= psel && penable && pready && pwrite && (paddr == calu_pkg::CALU_OFS_CMD);
	end
	sequence s_idle_setup;
		psel && !penable && !busy;
	endsequence
	sequence s_cmd_go;
		psel && penable && pready && pwrite && !pslverr && (paddr == calu_pkg::CALU_OFS_CMD) && pstrb[0];
	endsequence
	a_ready_pulse: assert property (pready |=> !pready) else $error("pready held longer than one cycle");
	a_err_ack: assert property (pslverr |-> pready) else $error("pslverr without pready");
	a_busy_stall: assert property (busy |-> !pready) else $error("transfer completed while busy");
	a_idle_answer: assert property (s_idle_setup |-> ##2 pready) else $error("idle transfer not answered in time");
	a_cmd_start: assert property (s_cmd_go |=> busy [*4]) else $error("instruction shorter than one cycle");
	a_busy_len: assert property ($fell(busy) |-> busy_cnt_q == 4'h4 || busy_cnt_q == 4'h8)
		else $error("busy run of wrong length");
	a_busy_cap: assert property (busy |-> busy_cnt_q < 4'h8) else $error("busy run too long");
	a_busy_cause: assert property ($rose(busy) |-> cmd_q) else $error("busy rose without a command write");
	a_write_quiet: assert property (pready && pwrite |-> prdata == 32'h0) else $error("read data on a write");
endmodule // calu_checker
////////////////////////////////////////////////////////////////////////////////
bind calu_core calu_checker u_chk (.clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr), .busy(busy));
`default_nettype wire

// *** calu_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        clock, reset, psel, penable, pwrite, pready, pslverr, busy, e;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0]  pstrb;
	int          failures, total_checks, n;
	// each entry: op, dest, bit, accumulator, file/literal, status
	logic [31:0] tbl [13] = '{32'h10F00F03, 32'h20887800, 32'h20010207, 32'h383C0F03, 32'h300FF000,
		32'h480F0100, 32'h40808000, 32'h50008100, 32'h58004001, 32'h60FF0001, 32'h68102001, 32'h7755FF07, 32'h78000100};
	calu_core dut (.clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr), .busy(busy));
	always #12.5 clock = ~clock;
	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	// one apb transfer; pready, read data and error are taken at the rising edge that completes it
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r, output logic er);
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		r = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, rd, e);
	endtask
	task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0, rd, e);
		chk(what, exp, rd);
	endtask
	function automatic logic [31:0] mk(input logic [2:0] op, input logic d, input logic [2:0] b, input logic p,
		input logic [6:0] f, input logic [7:0] k);
		mk = {8'h00, k, 1'b0, f, p, b, d, op};
	endfunction
	// loads operands, runs one instruction and compares accumulator, file and flags against a local model
	task automatic op_test(input logic [31:0] t);
		logic [2:0] op, b, st, es;
		logic [7:0] a, f, r, ea, ef;
		logic       d, ci, nib;
		logic [8:0] s9;
		{op, d, b, a, f, st} = {t[30:28], t[27], t[26:24], t[23:16], t[15:8], t[2:0]};
		ci = (op == 3'h6) ? st[0] : 1'b0;
		s9 = {1'b0, a} + {1'b0, f} + {8'h00, ci};
		nib = ({1'b0, a[3:0]} + {1'b0, f[3:0]} + {4'h0, ci}) > 5'hF;
		r = (op == 3'h1 || op == 3'h3) ? (a & f) : (op == 3'h5) ? {f[7], f[7:1]} : (op == 3'h7) ? (f & ~(8'h01 << b)) : s9[7:0];
		{ea, ef, es} = {a, f, st};
		if (op == 3'h7 || (d && op >= 3'h3)) ef = r;
		else ea = r;
		if (op != 3'h7) es[calu_pkg::CALU_ST_ZERO] = (r == 8'h00);
		if (op == 3'h2 || op == 3'h4 || op == 3'h6) es[1:0] = {nib, s9[8]};
		if (op == 3'h5) es[calu_pkg::CALU_ST_CARRY] = f[0];
		wr(calu_pkg::CALU_OFS_FADDR, 32'h7F);
		wr(calu_pkg::CALU_OFS_FDATA, {24'h0, f});
		wr(calu_pkg::CALU_OFS_ACCUM, {24'h0, a});
		wr(calu_pkg::CALU_OFS_STATUS, {29'h0, st});
		wr(calu_pkg::CALU_OFS_CMD, mk(op, d, b, 1'b0, 7'h7F, f));
		rdc("accumulator", calu_pkg::CALU_OFS_ACCUM, {24'h0, ea});
		rdc("file", calu_pkg::CALU_OFS_FDATA, {24'h0, ef});
		rdc("status", calu_pkg::CALU_OFS_STATUS, {29'h0, es});
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////
	// watchdog sized well beyond the few hundred cycles the sequence needs
	initial begin
		#(25 * 20000);
		failures++;
		stop_test();
	end
	initial begin
		{clock, reset, psel, penable, pwrite, paddr, pwdata, pstrb} = {2'b01, 3'b000, 8'h00, 32'h0, 4'hF};
		{failures, total_checks} = {32'sd0, 32'sd0};
		repeat (3) @(posedge clock);
		reset <= 1'b0;
		rdc("accum reset", calu_pkg::CALU_OFS_ACCUM, 32'h0);
		rdc("status reset", calu_pkg::CALU_OFS_STATUS, 32'h0);
		rdc("ptr0 reset", calu_pkg::CALU_OFS_PTR0, 32'h0);
		rdc("state reset", calu_pkg::CALU_OFS_STATE, 32'h0);
		rdc("unmapped data", 8'h20, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, e});
		wr(8'h20, 32'hFF);
		chk("unmapped write error", 32'h1, {31'h0, e});
		$display("test reset done");
		wr(calu_pkg::CALU_OFS_PTR0, 32'h5);
		wr(calu_pkg::CALU_OFS_STATUS, 32'h7);
		wr(calu_pkg::CALU_OFS_CMD, mk(3'h0, 1'b0, 3'h0, 1'b0, 7'h00, 8'h20));
		rdc("ptr0 sum", calu_pkg::CALU_OFS_PTR0, 32'hFFE5);
		rdc("ptr flags", calu_pkg::CALU_OFS_STATUS, 32'h7);
		wr(calu_pkg::CALU_OFS_PTR1, 32'hFFFF);
		wr(calu_pkg::CALU_OFS_CMD, mk(3'h0, 1'b0, 3'h0, 1'b1, 7'h00, 8'h1F));
		rdc("ptr1 sum", calu_pkg::CALU_OFS_PTR1, 32'h1E);
		$display("test pointer done");
		foreach (tbl[i]) op_test(tbl[i]);
		$display("test operations done");
		for (int i = 0; i < 3; i++) begin
			wr((i == 2) ? calu_pkg::CALU_OFS_PTR1 : calu_pkg::CALU_OFS_PTR0, (i == 1) ? 32'h8005 : 32'h0005);
			wr(calu_pkg::CALU_OFS_FADDR, 32'h5);
			wr(calu_pkg::CALU_OFS_FDATA, 32'h11);
			wr(calu_pkg::CALU_OFS_ACCUM, 32'h22);
			wr(calu_pkg::CALU_OFS_CMD, mk(3'h4, 1'b1, 3'h0, 1'b0,
				(i == 2) ? calu_pkg::CALU_IND_PORT1 : calu_pkg::CALU_IND_PORT0, 8'h00));
			n = 0;
			@(negedge clock);
			while (busy === 1'b1 && n < 20) begin
				n++;
				@(negedge clock);
			end
			chk("busy cycles", (i == 1) ? 32'h8 : 32'h4, n);
			rdc("indirect file", calu_pkg::CALU_OFS_FDATA, 32'h33);
		end
		$display("test indirect done");
		stop_test();
	end
endmodule // tb
`default_nettype wire
